/* File: arc_top.sv */
// The plain strobed port and the register addresses were chosen for this implementation.
`include "arc_map.svh"
module arc_top (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_armed,
   input wire logic i_trigger,
   input wire logic i_sampling_done,
   input wire logic [3:0] i_channel_present,
   input wire logic i_ref_on_req,
   input wire logic i_video_bw_req,
   output logic [31:0] o_rdata,
   output logic o_acquiring,
   output logic o_capture,
   output logic o_ets_enable,
   output logic o_video_bw,
   output logic o_ref_input,
   output logic [15:0] o_settings
);
   import arc_pkg::*;
   arc_bus_s bus;
   arc_flags_s set_flags;
   arc_flags_s clr_flags;
   arc_flags_s flags;
   arc_state_e state_reg;
   arc_thresh_e thresh_reg;
   logic mode_auto_reg;
   logic dist_view_reg;
   logic [31:0] tscale_reg;
   logic [15:0] saved_reg;
   logic saved_valid_reg;
   logic [15:0] err_reg;
   logic ref_reg;
   logic ets_en;
   logic ets_en_d_reg;
   logic [2:0] arm_s_reg, trig_s_reg, done_s_reg;
   logic ref_req_s1, ref_req_reg;
   logic vbw_s1, vbw_reg;
   logic [3:0] ch_s1, ch_reg;
   logic cmd_wr, cls, rst_cmd, fit_ok, undo_ok;
   logic trig_rise, done_rise;

   // command write decode
   function automatic logic cmd_is(input arc_bus_s b, input logic [3:0] c);
      cmd_is = b.wr && b.addr == `ARC_ADDR_CMD && b.wdata[3:0] == c;
   endfunction
   // query read decode
   function automatic logic read_at(input arc_bus_s b, input logic [3:0] a);
      read_at = b.rd && b.addr == a;
   endfunction

   assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
   assign cmd_wr = bus.wr && bus.addr == `ARC_ADDR_CMD;
   assign cls = cmd_is(bus, `ARC_CMD_CLS);
   assign rst_cmd = cmd_is(bus, `ARC_CMD_RST);
   assign fit_ok = cmd_is(bus, `ARC_CMD_FIT)
      && !dist_view_reg;
   assign undo_ok = cmd_is(bus, `ARC_CMD_UNDO)
      && !dist_view_reg && saved_valid_reg;

   // pin synchronisers, third stage for edges
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         arm_s_reg <= 3'h0;
         trig_s_reg <= 3'h0;
         done_s_reg <= 3'h0;
         ref_req_s1 <= 1'b0;
         ref_req_reg <= 1'b0;
         vbw_s1 <= 1'b0;
         vbw_reg <= 1'b0;
         ch_s1 <= 4'h0;
         ch_reg <= 4'h0;
      end else begin
         arm_s_reg <= {arm_s_reg[1:0], i_armed};
         trig_s_reg <= {trig_s_reg[1:0], i_trigger};
         done_s_reg <= {done_s_reg[1:0], i_sampling_done};
         ref_req_s1 <= i_ref_on_req;
         ref_req_reg <= ref_req_s1;
         vbw_s1 <= i_video_bw_req;
         vbw_reg <= vbw_s1;
         ch_s1 <= i_channel_present;
         ch_reg <= ch_s1;
      end
   end
   assign trig_rise = trig_s_reg[1] && !trig_s_reg[2];
   assign done_rise = done_s_reg[1] && !done_s_reg[2];

   assign set_flags.arm = arm_s_reg[1] && !arm_s_reg[2];
   assign set_flags.trig = trig_rise;
   assign set_flags.done = done_rise;
   assign clr_flags.arm = cls || read_at(bus, `ARC_ADDR_ARM_Q);
   assign clr_flags.trig = cls || read_at(bus, `ARC_ADDR_TRIG_Q);
   assign clr_flags.done = cls || read_at(bus, `ARC_ADDR_DONE_Q);

   arc_flag u_arm (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_set(set_flags.arm), .i_clear(clr_flags.arm), .o_flag(flags.arm));
   arc_flag u_trig (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_set(set_flags.trig), .i_clear(clr_flags.trig),
      .o_flag(flags.trig));
   arc_flag u_done (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_set(set_flags.done), .i_clear(clr_flags.done),
      .o_flag(flags.done));

   // acquisition state machine
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= ARC_RUN;
      end else if (rst_cmd) begin
         state_reg <= ARC_RUN;
      end else if (cmd_is(bus, `ARC_CMD_RUN)) begin
         state_reg <= ARC_RUN;
      end else if (cmd_is(bus, `ARC_CMD_SINGLE)) begin
         state_reg <= ARC_SINGLE;
      end else if (cmd_is(bus, `ARC_CMD_STOP)) begin
         state_reg <= ARC_STOP;
      end else begin
         case (state_reg)
            ARC_SINGLE: if (trig_rise) state_reg <= ARC_STOP;
            ARC_RUN: state_reg <= ARC_RUN;
            ARC_STOP: state_reg <= ARC_STOP;
            default: state_reg <= ARC_STOP;
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_acquiring <= 1'b1;
         o_capture <= 1'b0;
      end else begin
         o_acquiring <= state_reg != ARC_STOP;
         o_capture <= trig_rise && state_reg != ARC_STOP;
      end
   end

   // configuration registers
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_auto_reg <= 1'b1;
         thresh_reg <= ARC_THR_500N_SEL;
         dist_view_reg <= 1'b0;
         tscale_reg <= 32'h0000_0000;
      end else if (rst_cmd) begin
         mode_auto_reg <= 1'b1;
         thresh_reg <= ARC_THR_500N_SEL;
         dist_view_reg <= 1'b0;
      end else if (bus.wr) begin
         case (bus.addr)
            `ARC_ADDR_MODE: mode_auto_reg <= bus.wdata[0];
            `ARC_ADDR_THRESH: begin
               if (bus.wdata[2:0] <= 3'h4) begin
                  thresh_reg <= arc_thresh_e'(bus.wdata[2:0]);
               end
            end
            `ARC_ADDR_VIEW: dist_view_reg <= bus.wdata[0];
            `ARC_ADDR_TSCALE: tscale_reg <= bus.wdata;
            default: mode_auto_reg <= mode_auto_reg;
         endcase
      end
   end

   arc_ets u_ets (.i_auto(mode_auto_reg), .i_thresh(thresh_reg),
      .i_tscale_ns(tscale_reg), .o_enable(ets_en));

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ets_en_d_reg <= 1'b0;
         ref_reg <= 1'b0;
         err_reg <= 16'h0000;
      end else begin
         ets_en_d_reg <= ets_en;
         if (ets_en && !ets_en_d_reg && ref_reg) begin
            err_reg <= `ARC_ERR_REF;
         end else if (cls || read_at(bus, `ARC_ADDR_ERROR)) begin
            err_reg <= 16'h0000;
         end
         ref_reg <= ets_en ? 1'b0 : ref_req_reg;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_video_bw <= 1'b0;
         o_ets_enable <= 1'b0;
         o_ref_input <= 1'b0;
      end else begin
         o_video_bw <= vbw_reg && !ets_en;
         o_ets_enable <= ets_en;
         o_ref_input <= ref_reg && !ets_en;
      end
   end

   // fit sets channels, save and restore
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_settings <= `ARC_RST_SETTINGS;
         saved_reg <= `ARC_RST_SETTINGS;
         saved_valid_reg <= 1'b0;
      end else if (rst_cmd) begin
         o_settings <= `ARC_RST_SETTINGS;
         saved_valid_reg <= 1'b0;
      end else if (fit_ok) begin
         saved_reg <= o_settings;
         saved_valid_reg <= 1'b1;
         o_settings <= {o_settings[15:8], 4'hF, ch_reg};
      end else if (undo_ok) begin
         o_settings <= saved_reg;
      end else if (bus.wr && bus.addr == `ARC_ADDR_SETTINGS) begin
         o_settings <= bus.wdata[15:0];
      end
   end

   // read port, values
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 32'h0000_0000;
      end else if (bus.rd) begin
         case (bus.addr)
            `ARC_ADDR_MODE: o_rdata <= {31'h0, mode_auto_reg};
            `ARC_ADDR_THRESH: o_rdata <= {29'h0, thresh_reg};
            `ARC_ADDR_STATUS: o_rdata <= {25'h0, flags, ets_en,
               dist_view_reg, state_reg};
            `ARC_ADDR_ARM_Q: o_rdata <= {31'h0, flags.arm};
            `ARC_ADDR_TRIG_Q: o_rdata <= {31'h0, flags.trig};
            `ARC_ADDR_DONE_Q: o_rdata <= {31'h0, flags.done};
            `ARC_ADDR_VIEW: o_rdata <= {31'h0, dist_view_reg};
            `ARC_ADDR_TSCALE: o_rdata <= tscale_reg;
            `ARC_ADDR_SETTINGS: o_rdata <= {16'h0, o_settings};
            `ARC_ADDR_ERROR: o_rdata <= {16'h0, err_reg};
            default: o_rdata <= 32'h0000_0000;
         endcase
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   sequence s_single_cmd;
      cmd_is(bus, `ARC_CMD_SINGLE);
   endsequence
   sequence s_single_trig;
      state_reg == ARC_SINGLE && trig_rise && !cmd_wr;
   endsequence
   AST_SINGLE: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) s_single_cmd |=> state_reg == ARC_SINGLE)
      else $error("single not entered");
   AST_SINGLE_STOP: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) s_single_trig |=> state_reg == ARC_STOP)
      else $error("single did not stop after capture");
   AST_FIT_REFUSED: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) (cmd_is(bus, `ARC_CMD_FIT) && dist_view_reg)
      |=> $stable(o_settings))
      else $error("fit accepted in view mode");
   AST_UNDO_REFUSED: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) (cmd_is(bus, `ARC_CMD_UNDO) && dist_view_reg)
      |=> $stable(o_settings))
      else $error("undo accepted in view mode");
   AST_FIT_APPLY: assert property (@(posedge i_clock)
      disable iff (!i_rst_n)
      fit_ok |=> o_settings[7:0] == {4'hF, $past(ch_reg)})
      else $error("fit settings wrong");
   AST_UNDO_RESTORE: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) undo_ok |=> o_settings == $past(saved_reg))
      else $error("undo did not restore");
   AST_VBW_OFF: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) ets_en |=> !o_video_bw)
      else $error("video bandwidth on during sampling");
   AST_REF_OFF: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) ets_en |=> !o_ref_input)
      else $error("reference on during sampling");
   AST_REF_ERR: assert property (@(posedge i_clock)
      disable iff (!i_rst_n)
      (ets_en && !ets_en_d_reg && ref_reg) |=> err_reg == `ARC_ERR_REF)
      else $error("reference error missing");
   AST_MODE_OFF: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) !mode_auto_reg |=> !o_ets_enable)
      else $error("sampling on with mode off");
   AST_STOP_HOLDS: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) (state_reg == ARC_STOP && !cmd_wr)
      |=> state_reg == ARC_STOP)
      else $error("left stop without command");
   AST_RUN_HOLDS: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) (state_reg == ARC_RUN && !cmd_wr)
      |=> state_reg == ARC_RUN)
      else $error("left run without command");
   AST_ARM_READ: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) read_at(bus, `ARC_ADDR_ARM_Q)
      |=> o_rdata[0] == $past(flags.arm))
      else $error("arm query wrong");
   AST_TRIG_READ: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) read_at(bus, `ARC_ADDR_TRIG_Q)
      |=> o_rdata[0] == $past(flags.trig))
      else $error("trigger query wrong");
   AST_DONE_READ: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) read_at(bus, `ARC_ADDR_DONE_Q)
      |=> o_rdata[0] == $past(flags.done))
      else $error("sampling done query wrong");
   AST_ARM_CLR: assert property (@(posedge i_clock)
      disable iff (!i_rst_n)
      (read_at(bus, `ARC_ADDR_ARM_Q) && !set_flags.arm) |=> !flags.arm)
      else $error("arm flag not cleared");
   AST_TRIG_CLR: assert property (@(posedge i_clock)
      disable iff (!i_rst_n)
      (read_at(bus, `ARC_ADDR_TRIG_Q) && !set_flags.trig) |=> !flags.trig)
      else $error("trigger flag not cleared");
   AST_DONE_CLR: assert property (@(posedge i_clock)
      disable iff (!i_rst_n)
      (read_at(bus, `ARC_ADDR_DONE_Q) && !set_flags.done) |=> !flags.done)
      else $error("sampling done flag not cleared");
   AST_CLS_CLR: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) (cls && set_flags == 3'b000) |=> flags == 3'b000)
      else $error("clear-status left a flag set");
   AST_STATUS_KEEPS: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) read_at(bus, `ARC_ADDR_STATUS)
      |=> (flags & $past(flags)) == $past(flags))
      else $error("status read cleared a flag");
   AST_RST_RUN: assert property (@(posedge i_clock)
      disable iff (!i_rst_n)
      rst_cmd |=> state_reg == ARC_RUN && mode_auto_reg)
      else $error("reset defaults missing");
   AST_THR_RST: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) rst_cmd |=> thresh_reg == ARC_THR_500N_SEL)
      else $error("reset threshold wrong");
endmodule

/* File: arc_map.svh */
`ifndef ARC_MAP_SVH
`define ARC_MAP_SVH
`define ARC_ADDR_CMD 4'h0
`define ARC_ADDR_MODE 4'h1
`define ARC_ADDR_THRESH 4'h2
`define ARC_ADDR_STATUS 4'h3
`define ARC_ADDR_ARM_Q 4'h4
`define ARC_ADDR_TRIG_Q 4'h5
`define ARC_ADDR_DONE_Q 4'h6
`define ARC_ADDR_VIEW 4'h7
`define ARC_ADDR_TSCALE 4'h8
`define ARC_ADDR_SETTINGS 4'h9
`define ARC_ADDR_ERROR 4'hA
`define ARC_CMD_RUN 4'h1
`define ARC_CMD_SINGLE 4'h2
`define ARC_CMD_STOP 4'h3
`define ARC_CMD_CLS 4'h4
`define ARC_CMD_RST 4'h5
`define ARC_CMD_FIT 4'h6
`define ARC_CMD_UNDO 4'h7
`define ARC_ERR_REF 16'h03AB
`define ARC_THR_500N 32'h0000_01F4
`define ARC_THR_1U 32'h0000_03E8
`define ARC_THR_2U 32'h0000_07D0
`define ARC_THR_5U 32'h0000_1388
`define ARC_THR_10U 32'h0000_2710
`define ARC_RST_SETTINGS 16'h000F
`endif

/* File: arc_pkg.sv */
package arc_pkg;
   typedef enum logic [2:0] {
      ARC_THR_500N_SEL, ARC_THR_1U_SEL, ARC_THR_2U_SEL,
      ARC_THR_5U_SEL, ARC_THR_10U_SEL
   } arc_thresh_e;
   typedef enum logic [1:0] {ARC_RUN, ARC_SINGLE, ARC_STOP} arc_state_e;
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } arc_bus_s;
   typedef struct packed {
      logic arm;
      logic trig;
      logic done;
   } arc_flags_s;
endpackage

/* File: arc_flag.sv */
module arc_flag (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_set,
   input wire logic i_clear,
   output logic o_flag
);
   // sticky, set beats clear
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_flag <= 1'b0;
      end else if (i_set) begin
         o_flag <= 1'b1;
      end else if (i_clear) begin
         o_flag <= 1'b0;
      end
   end
   AST_SET_WINS: assert property (@(posedge i_clock)
      disable iff (!i_rst_n) i_set |=> o_flag)
      else $error("flag lost its set");
endmodule

/* File: arc_ets.sv */
`include "arc_map.svh"
module arc_ets (
   input wire logic i_auto,
   input wire arc_pkg::arc_thresh_e i_thresh,
   input wire logic [31:0] i_tscale_ns,
   output logic o_enable
);
   import arc_pkg::*;
   function automatic logic [31:0] thr_ns(input arc_thresh_e t);
      case (t)
         ARC_THR_500N_SEL: thr_ns = `ARC_THR_500N;
         ARC_THR_1U_SEL: thr_ns = `ARC_THR_1U;
         ARC_THR_2U_SEL: thr_ns = `ARC_THR_2U;
         ARC_THR_5U_SEL: thr_ns = `ARC_THR_5U;
         ARC_THR_10U_SEL: thr_ns = `ARC_THR_10U;
         default: thr_ns = `ARC_THR_500N;
      endcase
   endfunction
   assign o_enable = i_auto && (i_tscale_ns < thr_ns(i_thresh));
endmodule

/* File: arc_evt_src.sv */
module arc_evt_src (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [2:0] i_fire,
   input wire logic i_slow,
   output logic [2:0] o_pins
);
   logic [2:0] cnt_reg [3];
   // delayed event pulse, two cycles wide, prompt or slow
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int k = 0; k < 3; k++) begin
            cnt_reg[k] <= 3'h0;
         end
      end else begin
         for (int k = 0; k < 3; k++) begin
            if (i_fire[k]) begin
               cnt_reg[k] <= i_slow ? 3'h5 : 3'h2;
            end else if (cnt_reg[k] != 3'h0) begin
               cnt_reg[k] <= cnt_reg[k] - 3'h1;
            end
         end
      end
   end
   always_comb begin
      for (int k = 0; k < 3; k++) begin
         o_pins[k] = (cnt_reg[k] == 3'h1) || (cnt_reg[k] == 3'h2);
      end
   end
endmodule

/* File: arc_top_tb.sv */
`include "arc_map.svh"
module acquisition_run_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import arc_pkg::*;
   arc_bus_s bus;
   logic i_clock, i_rst_n, i_ref_on_req, i_video_bw_req, slow, rd_seen;
   logic o_acquiring, o_capture, o_ets_enable, o_video_bw, o_ref_input;
   logic [3:0] i_channel_present;
   logic [2:0] pins, fire;
   logic [31:0] o_rdata;
   logic [31:0] exp_fit;
   logic [15:0] o_settings;
   logic [31:0] exp_q[$];
   string nm_q[$];
   logic [31:0] thr [5];
   int num_errors, n_tests, n_cap, seed, c;
   arc_top dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(bus.addr),
      .i_wdata(bus.wdata), .i_wr(bus.wr), .i_rd(bus.rd), .i_armed(pins[0]),
      .i_trigger(pins[1]), .i_sampling_done(pins[2]),
      .i_channel_present(i_channel_present), .i_ref_on_req(i_ref_on_req),
      .i_video_bw_req(i_video_bw_req), .o_rdata(o_rdata),
      .o_acquiring(o_acquiring), .o_capture(o_capture),
      .o_ets_enable(o_ets_enable), .o_video_bw(o_video_bw),
      .o_ref_input(o_ref_input), .o_settings(o_settings));
   arc_evt_src src (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_fire(fire),
      .i_slow(slow), .o_pins(pins));
   always #20 i_clock = ~i_clock;
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkb(input string nm, input logic e, input logic g);
      chk(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clock);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge i_clock);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge i_clock);
      bus.addr <= a;
      bus.rd <= 1'b1;
      exp_q.push_back(e);
      nm_q.push_back($sformatf("read %h", a));
      @(posedge i_clock);
      bus.rd <= 1'b0;
   endtask
   task automatic pause(input int n);
      repeat (n) @(posedge i_clock);
      @(negedge i_clock);
   endtask
   task automatic ev(input int k);
      @(posedge i_clock);
      fire <= 3'(1 << k);
      @(posedge i_clock);
      fire <= 3'h0;
      pause(8);
   endtask
   function automatic logic [31:0] st(input logic [2:0] f, input logic e,
         input logic [1:0] s);
      return {25'h0, f, e, 1'b0, s};
   endfunction
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // read result monitor, oldest note first
   always @(posedge i_clock) rd_seen <= bus.rd;
   always @(negedge i_clock) begin
      if (rd_seen === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("unexpected read", 32'h0000_0000, 32'hFFFF_FFFF);
         end else begin
            chk(nm_q.pop_front(), exp_q.pop_front(), o_rdata);
         end
      end
   end
   always @(posedge i_clock) if (o_capture === 1'b1) n_cap++;
   initial begin
      #2_000_000;
      num_errors++;
      test_done();
   end
   initial begin
      i_clock = 0;
      bus = '0;
      i_rst_n = 0;
      i_channel_present = 4'h5;
      i_ref_on_req = 1;
      i_video_bw_req = 1;
      fire = 3'h0;
      slow = 0;
      seed = 86;
      thr = '{`ARC_THR_500N, `ARC_THR_1U, `ARC_THR_2U, `ARC_THR_5U,
         `ARC_THR_10U};
      repeat (10) @(posedge i_clock);
      i_rst_n <= 1'b1;
      pause(0);
      chkb("acquiring", 1'b1, o_acquiring);
      chk("settings", `ARC_RST_SETTINGS, {16'h0, o_settings});
      rd(`ARC_ADDR_MODE, 32'h0000_0001);
      rd(`ARC_ADDR_THRESH, 32'h0000_0000);
      wr(`ARC_ADDR_MODE, 32'h0000_0000);
      pause(4);
      chkb("ets off", 1'b0, o_ets_enable);
      chkb("video", 1'b1, o_video_bw);
      chkb("ref on", 1'b1, o_ref_input);
      $display("test reset done");
      for (int k = 0; k < 3; k++) begin
         slow = k[0];
         ev(k);
         rd(`ARC_ADDR_STATUS, st(3'b100 >> k, 1'b0, 2'h0));
         rd(`ARC_ADDR_STATUS, st(3'b100 >> k, 1'b0, 2'h0));
         rd(4'(`ARC_ADDR_ARM_Q + k), 32'h0000_0001);
         rd(4'(`ARC_ADDR_ARM_Q + k), 32'h0000_0000);
      end
      for (int k = 0; k < 3; k++) ev(k);
      wr(`ARC_ADDR_CMD, `ARC_CMD_CLS);
      rd(`ARC_ADDR_STATUS, st(3'b000, 1'b0, 2'h0));
      for (int k = 0; k < 3; k++) rd(4'(`ARC_ADDR_ARM_Q + k), 32'h0);
      $display("test flags done");
      for (int k = 0; k < 5; k++) begin
         wr(`ARC_ADDR_THRESH, 32'(k));
         wr(`ARC_ADDR_TSCALE, thr[k] + $unsigned($random(seed)) % 1000);
         wr(`ARC_ADDR_MODE, 32'h0000_0001);
         pause(4);
         chkb("ets above", 1'b0, o_ets_enable);
         wr(`ARC_ADDR_TSCALE, $unsigned($random(seed)) % thr[k]);
         pause(4);
         chkb("ets below", 1'b1, o_ets_enable);
         chkb("video forced", 1'b0, o_video_bw);
         chkb("ref off", 1'b0, o_ref_input);
         if (k == 0) begin
            rd(`ARC_ADDR_ERROR, {16'h0, `ARC_ERR_REF});
            rd(`ARC_ADDR_ERROR, 32'h0000_0000);
            rd(`ARC_ADDR_STATUS, st(3'b000, 1'b1, 2'h0));
         end
         rd(`ARC_ADDR_THRESH, 32'(k));
         wr(`ARC_ADDR_MODE, 32'h0000_0000);
         pause(4);
         chkb("ets mode off", 1'b0, o_ets_enable);
      end
      wr(`ARC_ADDR_THRESH, 32'h0000_0005);
      rd(`ARC_ADDR_THRESH, 32'h0000_0004);
      $display("test sampling done");
      wr(`ARC_ADDR_CMD, `ARC_CMD_STOP);
      pause(2);
      chkb("stopped", 1'b0, o_acquiring);
      rd(`ARC_ADDR_STATUS, st(3'b000, 1'b0, 2'h2));
      c = n_cap;
      ev(1);
      chk("no capture", 32'(c), 32'(n_cap));
      rd(`ARC_ADDR_TRIG_Q, 32'h0000_0001);
      wr(`ARC_ADDR_CMD, `ARC_CMD_SINGLE);
      pause(2);
      chkb("single", 1'b1, o_acquiring);
      rd(`ARC_ADDR_STATUS, st(3'b000, 1'b0, 2'h1));
      ev(1);
      chk("single capture", 32'(c + 1), 32'(n_cap));
      chkb("ceased", 1'b0, o_acquiring);
      rd(`ARC_ADDR_TRIG_Q, 32'h0000_0001);
      wr(`ARC_ADDR_CMD, `ARC_CMD_RUN);
      ev(1);
      ev(1);
      chk("run captures", 32'(c + 3), 32'(n_cap));
      chkb("running", 1'b1, o_acquiring);
      rd(`ARC_ADDR_TRIG_Q, 32'h0000_0001);
      wr(`ARC_ADDR_THRESH, 32'h0000_0003);
      wr(`ARC_ADDR_CMD, `ARC_CMD_STOP);
      wr(`ARC_ADDR_CMD, `ARC_CMD_RST);
      pause(2);
      chkb("reset run", 1'b1, o_acquiring);
      rd(`ARC_ADDR_MODE, 32'h0000_0001);
      rd(`ARC_ADDR_THRESH, 32'h0000_0000);
      $display("test acquisition done");
      i_channel_present <= 4'($random(seed));
      wr(`ARC_ADDR_CMD, `ARC_CMD_UNDO);
      pause(2);
      chk("undo early", `ARC_RST_SETTINGS, {16'h0, o_settings});
      exp_fit = {24'h0, 4'hF, i_channel_present};
      wr(`ARC_ADDR_VIEW, 32'h0000_0001);
      rd(`ARC_ADDR_VIEW, 32'h0000_0001);
      wr(`ARC_ADDR_CMD, `ARC_CMD_FIT);
      pause(2);
      chk("fit refused", `ARC_RST_SETTINGS, {16'h0, o_settings});
      wr(`ARC_ADDR_VIEW, 32'h0000_0000);
      wr(`ARC_ADDR_CMD, `ARC_CMD_FIT);
      pause(2);
      chk("fit", exp_fit, {16'h0, o_settings});
      rd(`ARC_ADDR_SETTINGS, exp_fit);
      wr(`ARC_ADDR_VIEW, 32'h0000_0001);
      wr(`ARC_ADDR_CMD, `ARC_CMD_UNDO);
      pause(2);
      chk("undo refused", exp_fit, {16'h0, o_settings});
      wr(`ARC_ADDR_VIEW, 32'h0000_0000);
      wr(`ARC_ADDR_CMD, `ARC_CMD_UNDO);
      pause(2);
      chk("undo", `ARC_RST_SETTINGS, {16'h0, o_settings});
      rd(4'hB, 32'h0000_0000);
      pause(4);
      $display("test autofit done");
      test_done();
   end
endmodule
